/* File: rtl/pfg_override.sv */
`timescale 1ns/100ps


module pfg_override
    import pfg_pkg::*;
#(
    parameter int PF_W = PFG_PF_W,
    parameter int PG_W = PFG_PG_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // port F general-purpose settings
    input wire logic [PF_W-1:0] pf_port,
    input wire logic [PF_W-1:0] pf_dir,
    // port G general-purpose settings
    input wire logic [PG_W-1:0] pg_port,
    input wire logic [PG_W-1:0] pg_dir,
    // global configuration
    input wire logic pull_up_disable,
    input wire logic legacy_mode,
    input wire logic scan_port_enable,
    input wire logic async_timer_clock_select,
    input wire logic ext_mem_enable,
    // scan state machine handshake
    input wire logic tap_in_instruction_shift,
    input wire logic tap_in_data_shift,
    input wire logic scan_tdo,
    output logic scan_tdi_bit,
    output logic scan_tms_bit,
    output logic scan_tck_rise,
    output logic scan_tck_fall,
    // external memory strobes
    input wire logic ext_mem_latch,
    input wire logic ext_mem_read,
    input wire logic ext_mem_write,
    // port F pins
    input wire logic [PF_W-1:0] pf_pin_in,
    output logic [PF_W-1:0] pf_pin_out,
    output logic [PF_W-1:0] pf_pin_oe,
    output logic [PF_W-1:0] pf_pin_pullup,
    // port G pins
    input wire logic [PG_W-1:0] pg_pin_in,
    output logic [PG_W-1:0] pg_pin_out,
    output logic [PG_W-1:0] pg_pin_oe,
    output logic [PG_W-1:0] pg_pin_pullup,
    // analog and crystal links
    output logic [PF_W-1:0] analog_pin_link,
    output logic timer_crystal_in,
    output logic timer_crystal_out,
    // synchronised digital inputs
    output logic [PF_W-1:0] pf_in_sync,
    output logic [PG_W-1:0] pg_in_sync
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    pfg_ovr_t pf_ovr [PF_W];
    pfg_ovr_t pg_ovr [PG_W];
    pfg_pinctl_t pf_ctl [PF_W];
    pfg_pinctl_t pg_ctl [PG_W];
    logic [PF_W-1:0] pf_meta_r;
    logic [PF_W-1:0] pf_sync_r;
    logic [PG_W-1:0] pg_meta_r;
    logic [PG_W-1:0] pg_sync_r;
    logic [PF_W-1:0] pf_in_r;
    logic [PG_W-1:0] pg_in_r;
    logic [PF_W-1:0] pf_in_nxt;
    logic [PG_W-1:0] pg_in_nxt;
    logic tck_prev_r;
    logic tck_now;
    logic tdi_r;
    logic tms_r;
    logic tdo_r;
    logic tdo_oe_r;
    logic tck_rise;
    logic tck_fall;
    logic scan_shifting;
    logic [PF_W-1:0] pf_dir_eff;
    logic [PG_W-1:0] pg_dir_eff;
    logic [PG_W-1:0] pg_port_eff;

    // ------------------------------------------------------------------
    // two-flop synchronisers on all pin inputs
    // ------------------------------------------------------------------

    // first stage only feeds the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_meta_r <= PFG_PF_RST;
            pf_sync_r <= PFG_PF_RST;
            pg_meta_r <= PFG_PG_RST;
            pg_sync_r <= PFG_PG_RST;
        end else begin
            pf_meta_r <= pf_pin_in;
            pf_sync_r <= pf_meta_r;
            pg_meta_r <= pg_pin_in;
            pg_sync_r <= pg_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // scan clock edge finder
    // ------------------------------------------------------------------
    assign tck_now = pf_sync_r[PFG_PF_TCK];

    // previous scan clock level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_prev_r <= PFG_BIT_RST;
        end else begin
            tck_prev_r <= tck_now;
        end
    end

    // edges only count while the scan port owns the pins
    assign tck_rise = scan_port_enable & tck_now & ~tck_prev_r;
    assign tck_fall = scan_port_enable & ~tck_now & tck_prev_r;
    assign scan_tck_rise = tck_rise;
    assign scan_tck_fall = tck_fall;

    // ------------------------------------------------------------------
    // scan data and mode capture on the rising scan clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tdi_r <= PFG_BIT_RST;
            tms_r <= PFG_BIT_RST;
        end else if (tck_rise) begin
            tdi_r <= pf_sync_r[PFG_PF_TDI];
            tms_r <= pf_sync_r[PFG_PF_TMS];
        end
    end

    assign scan_tdi_bit = tdi_r;
    assign scan_tms_bit = tms_r;

    // ------------------------------------------------------------------
    // scan data out, launched on the falling scan clock
    // ------------------------------------------------------------------
    assign scan_shifting = tap_in_instruction_shift | tap_in_data_shift;

    // output bit and its driver enable change together on a falling edge; scan port off clears only the enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tdo_r <= PFG_BIT_RST;
            tdo_oe_r <= PFG_BIT_RST;
        end else if (!scan_port_enable) begin
            tdo_oe_r <= PFG_BIT_RST;
        end else if (tck_fall) begin
            tdo_r <= scan_tdo;
            tdo_oe_r <= scan_shifting;
        end
    end

    // ------------------------------------------------------------------
    // general-purpose settings after legacy masking
    // ------------------------------------------------------------------

    // legacy mode: port F input only, port G input only with its pull-ups off
    assign pf_dir_eff = legacy_mode ? '0 : pf_dir;
    assign pg_dir_eff = legacy_mode ? '0 : pg_dir;
    assign pg_port_eff = legacy_mode ? '0 : pg_port;

    // ------------------------------------------------------------------
    // port F override table
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < PF_W; i++) begin
            pf_ovr[i] = PFG_OVR_NONE;
        end
        for (int i = PFG_PF_SCAN_LO; i < PF_W; i++) begin
            pf_ovr[i].pullup_override_enable = scan_port_enable;
            pf_ovr[i].pullup_override_value = 1'b1;
            pf_ovr[i].direction_override_enable = scan_port_enable;
            pf_ovr[i].direction_override_value = 1'b0;
            pf_ovr[i].input_gate_override_enable = scan_port_enable;
            pf_ovr[i].input_gate_override_value = 1'b0;
        end
        // data out pin: no pull-up, driven only while shifting
        pf_ovr[PFG_PF_TDO].pullup_override_value = 1'b0;
        pf_ovr[PFG_PF_TDO].direction_override_value = tdo_oe_r;
        pf_ovr[PFG_PF_TDO].out_value_override_enable = scan_port_enable;
        pf_ovr[PFG_PF_TDO].out_value_override_value = tdo_r;
    end

    // ------------------------------------------------------------------
    // port G override table
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < PG_W; i++) begin
            pg_ovr[i] = PFG_OVR_NONE;
        end
        // crystal pins leave the port entirely
        for (int i = PFG_PG_TOSC_OUT; i <= PFG_PG_TOSC_IN; i++) begin
            pg_ovr[i].pullup_override_enable = async_timer_clock_select;
            pg_ovr[i].pullup_override_value = 1'b0;
            pg_ovr[i].direction_override_enable = async_timer_clock_select;
            pg_ovr[i].direction_override_value = 1'b0;
            pg_ovr[i].input_gate_override_enable = async_timer_clock_select;
            pg_ovr[i].input_gate_override_value = 1'b0;
        end
        // memory strobes are forced outputs
        for (int i = PFG_PG_WR; i <= PFG_PG_ALE; i++) begin
            pg_ovr[i].pullup_override_enable = ext_mem_enable;
            pg_ovr[i].pullup_override_value = 1'b0;
            pg_ovr[i].direction_override_enable = ext_mem_enable;
            pg_ovr[i].direction_override_value = 1'b1;
            pg_ovr[i].out_value_override_enable = ext_mem_enable;
        end
        pg_ovr[PFG_PG_ALE].out_value_override_value = ext_mem_latch;
        pg_ovr[PFG_PG_RD].out_value_override_value = ext_mem_read;
        pg_ovr[PFG_PG_WR].out_value_override_value = ext_mem_write;
    end

    // ------------------------------------------------------------------
    // per-pin muxes
    // ------------------------------------------------------------------
    for (genvar g = 0; g < PF_W; g++) begin : g_pf
        pfg_pin_mux u_mux (
            .gpio(pfg_gpio_t'{port_bit: pf_port[g], dir_bit: pf_dir_eff[g],
                    pull_up_disable: pull_up_disable}),
            .ovr(pf_ovr[g]),
            .ctl(pf_ctl[g])
        );
    end

    for (genvar g = 0; g < PG_W; g++) begin : g_pg
        pfg_pin_mux u_mux (
            .gpio(pfg_gpio_t'{port_bit: pg_port_eff[g], dir_bit: pg_dir_eff[g],
                    pull_up_disable: pull_up_disable | legacy_mode}),
            .ovr(pg_ovr[g]),
            .ctl(pg_ctl[g])
        );
    end

    // ------------------------------------------------------------------
    // pin drive; combinational so scan pull-ups hold through reset
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < PF_W; i++) begin
            pf_pin_out[i] = pf_ctl[i].out_val;
            pf_pin_oe[i] = pf_ctl[i].out_en & (~legacy_mode | scan_port_enable);
            pf_pin_pullup[i] = pf_ctl[i].pullup_en;
            pf_in_nxt[i] = pf_sync_r[i] & pf_ctl[i].in_en;
        end
        for (int i = 0; i < PG_W; i++) begin
            pg_pin_out[i] = pg_ctl[i].out_val;
            pg_pin_oe[i] = pg_ctl[i].out_en;
            pg_pin_pullup[i] = pg_ctl[i].pullup_en;
            pg_in_nxt[i] = pg_sync_r[i] & pg_ctl[i].in_en;
        end
    end

    // ------------------------------------------------------------------
    // gated digital input readback
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_in_r <= PFG_PF_RST;
            pg_in_r <= PFG_PG_RST;
        end else begin
            pf_in_r <= pf_in_nxt;
            pg_in_r <= pg_in_nxt;
        end
    end

    assign pf_in_sync = pf_in_r;
    assign pg_in_sync = pg_in_r;

    // ------------------------------------------------------------------
    // analog paths: converter inputs and crystal amplifier
    // ------------------------------------------------------------------
    assign analog_pin_link = pf_pin_in;
    assign timer_crystal_in = async_timer_clock_select & pg_pin_in[PFG_PG_TOSC_IN];
    assign timer_crystal_out = async_timer_clock_select & pg_pin_in[PFG_PG_TOSC_OUT];

endmodule : pfg_override

/* File: rtl/pfg_pkg.sv */
package pfg_pkg;

    // ------------------------------------------------------------------
    // widths and pin positions
    // ------------------------------------------------------------------
    localparam int PFG_PF_W = 8;
    localparam int PFG_PG_W = 5;
    localparam int PFG_PF_TDI = 7;
    localparam int PFG_PF_TDO = 6;
    localparam int PFG_PF_TMS = 5;
    localparam int PFG_PF_TCK = 4;
    localparam int PFG_PF_SCAN_LO = 4;
    localparam int PFG_PG_TOSC_IN = 4;
    localparam int PFG_PG_TOSC_OUT = 3;
    localparam int PFG_PG_ALE = 2;
    localparam int PFG_PG_RD = 1;
    localparam int PFG_PG_WR = 0;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] PFG_PF_RST = 8'h00;
    localparam logic [4:0] PFG_PG_RST = 5'h00;
    localparam logic PFG_BIT_RST = 1'b0;
    localparam int PFG_SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // override bundle for one pin
    // ------------------------------------------------------------------
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic out_value_override_enable;
        logic out_value_override_value;
        logic input_gate_override_enable;
        logic input_gate_override_value;
    } pfg_ovr_t;

    // general-purpose settings for one pin
    typedef struct packed {
        logic port_bit;
        logic dir_bit;
        logic pull_up_disable;
    } pfg_gpio_t;

    // resolved pin control
    typedef struct packed {
        logic pullup_en;
        logic out_en;
        logic out_val;
        logic in_en;
    } pfg_pinctl_t;

    localparam pfg_ovr_t PFG_OVR_NONE = '0;

endpackage : pfg_pkg

/* File: rtl/pfg_pin_mux.sv */
`timescale 1ns/100ps

module pfg_pin_mux
    import pfg_pkg::*;
(
    // general-purpose settings
    input wire pfg_gpio_t gpio,
    // alternate-function overrides
    input wire pfg_ovr_t ovr,
    // resolved pin control
    output pfg_pinctl_t ctl
);

    // --------------------------------------------------------------
    // per-attribute override select
    // --------------------------------------------------------------
    always_comb begin
        ctl.pullup_en = ovr.pullup_override_enable ? ovr.pullup_override_value :
            (gpio.port_bit & ~gpio.dir_bit & ~gpio.pull_up_disable);
        ctl.out_en = ovr.direction_override_enable ? ovr.direction_override_value :
            gpio.dir_bit;
        ctl.out_val = ovr.out_value_override_enable ? ovr.out_value_override_value :
            gpio.port_bit;
        ctl.in_en = ovr.input_gate_override_enable ? ovr.input_gate_override_value :
            1'b1;
    end

endmodule : pfg_pin_mux

/* File: tb/pfg_override_sva.sv */
`timescale 1ns/100ps

// --------------------------------------------------------------
// checker on the override block ports
// --------------------------------------------------------------
module pfg_override_sva
    import pfg_pkg::*;
#(
    parameter int PF_W = PFG_PF_W,
    parameter int PG_W = PFG_PG_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // configuration
    input wire logic [PF_W-1:0] pf_dir,
    input wire logic legacy_mode,
    input wire logic scan_port_enable,
    input wire logic async_timer_clock_select,
    input wire logic ext_mem_enable,
    // scan handshake
    input wire logic tap_in_instruction_shift,
    input wire logic tap_in_data_shift,
    input wire logic scan_tdo,
    input wire logic scan_tdi_bit,
    input wire logic scan_tms_bit,
    input wire logic scan_tck_rise,
    input wire logic scan_tck_fall,
    // memory strobes
    input wire logic ext_mem_latch,
    input wire logic ext_mem_read,
    input wire logic ext_mem_write,
    // pins and links
    input wire logic [PF_W-1:0] pf_pin_in,
    input wire logic [PF_W-1:0] pf_pin_out,
    input wire logic [PF_W-1:0] pf_pin_oe,
    input wire logic [PF_W-1:0] pf_pin_pullup,
    input wire logic [PG_W-1:0] pg_pin_in,
    input wire logic [PG_W-1:0] pg_pin_out,
    input wire logic [PG_W-1:0] pg_pin_oe,
    input wire logic [PG_W-1:0] pg_pin_pullup,
    input wire logic [PF_W-1:0] analog_pin_link,
    input wire logic timer_crystal_in,
    input wire logic [PF_W-1:0] pf_in_sync,
    input wire logic [PG_W-1:0] pg_in_sync
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // --------------------------------------------------------------
    // port F
    // --------------------------------------------------------------
    a_analog_copy: assert property (analog_pin_link == pf_pin_in)
        else $error("converter link differs from pins");
    a_legacy_no_drive: assert property (legacy_mode && !scan_port_enable |-> pf_pin_oe == '0)
        else $error("port F driven in legacy mode");
    a_scan_pullup: assert property (scan_port_enable |-> pf_pin_pullup[7:4] == 4'hB)
        else $error("scan pull-ups wrong");
    a_scan_dir: assert property (scan_port_enable |-> !pf_pin_oe[7] && pf_pin_oe[5:4] == 2'h0)
        else $error("scan input pin driven");
    a_scan_gate: assert property (scan_port_enable [*4] |-> pf_in_sync[7:4] == 4'h0)
        else $error("scan pins not gated");
    a_tdi_sample: assert property (scan_tck_rise |=>
        scan_tdi_bit == $past(pf_pin_in[7], 3) && scan_tms_bit == $past(pf_pin_in[5], 3))
        else $error("scan data or mode bit not sampled");
    a_tdo_update: assert property (scan_tck_fall ##1 scan_port_enable |->
        pf_pin_oe[6] == $past(tap_in_instruction_shift || tap_in_data_shift)
        && pf_pin_out[6] == $past(scan_tdo))
        else $error("scan output not updated on fall");
    a_tck_follow: assert property ($rose(pf_pin_in[4]) && scan_port_enable |-> ##[1:4] scan_tck_rise)
        else $error("scan clock rise missed");
    a_low_bypass: assert property (!legacy_mode |-> pf_pin_oe[3:0] == pf_dir[3:0])
        else $error("low port F bits overridden");

    // --------------------------------------------------------------
    // port G
    // --------------------------------------------------------------
    a_crystal_pins: assert property (async_timer_clock_select |->
        pg_pin_oe[4:3] == 2'h0 && pg_pin_pullup[4:3] == 2'h0 && timer_crystal_in == pg_pin_in[4])
        else $error("crystal pins not released");
    a_crystal_gate: assert property (async_timer_clock_select [*4] |-> pg_in_sync[4:3] == 2'h0)
        else $error("crystal pins not gated");
    a_mem_strobes: assert property (ext_mem_enable |-> pg_pin_oe[2:0] == 3'h7
        && pg_pin_pullup[2:0] == 3'h0 && pg_pin_out[2:0] == {ext_mem_latch, ext_mem_read, ext_mem_write})
        else $error("memory strobes not forced");

    // main scenarios
    c_tdo_drive: cover property (scan_tck_fall ##1 pf_pin_oe[6]);
    c_mem: cover property (ext_mem_enable && legacy_mode);
    c_crystal: cover property (async_timer_clock_select [*4]);
endmodule : pfg_override_sva

bind pfg_override pfg_override_sva #(.PF_W(PF_W), .PG_W(PG_W)) i_sva (.clk, .arst_n, .pf_dir,
    .legacy_mode, .scan_port_enable, .async_timer_clock_select, .ext_mem_enable,
    .tap_in_instruction_shift, .tap_in_data_shift, .scan_tdo, .scan_tdi_bit, .scan_tms_bit,
    .scan_tck_rise, .scan_tck_fall, .ext_mem_latch, .ext_mem_read, .ext_mem_write, .pf_pin_in,
    .pf_pin_out, .pf_pin_oe, .pf_pin_pullup, .pg_pin_in, .pg_pin_out, .pg_pin_oe, .pg_pin_pullup,
    .analog_pin_link, .timer_crystal_in, .pf_in_sync, .pg_in_sync);

/* File: tb/pfg_scan_host.sv */
`timescale 1ns/100ps

// --------------------------------------------------------------
// scan host: one 80 ns clock period per request
// --------------------------------------------------------------
module pfg_scan_host (
    // request
    input wire logic go,
    input wire logic tdi_v,
    input wire logic tms_v,
    // scan pins
    output logic tck,
    output logic tdi,
    output logic tms
);
    // clock idles low, data lines sit at the pull-up level
    initial begin
        tck = 1'h0;
        tdi = 1'h1;
        tms = 1'h1;
    end

    // data set up before the rising clock, released after the fall
    always @(posedge go) begin
        #3 tdi = tdi_v;
        tms = tms_v;
        #40 tck = 1'h1;
        #40 tck = 1'h0;
        #10 tdi = 1'h1;
        tms = 1'h1;
    end
endmodule : pfg_scan_host

/* File: tb/tb_top.sv */
`timescale 1ns/100ps

module tb_top
    import pfg_pkg::*;
;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] pf_port, pf_dir, pf_drv, pf_lvl, pf_pin_in, pf_pin_out, pf_pin_oe, pf_pin_pullup;
    logic [7:0] analog_pin_link, pf_in_sync;
    logic [4:0] pg_port, pg_dir, pg_drv, pg_pin_in, pg_pin_out, pg_pin_oe, pg_pin_pullup, pg_in_sync;
    logic pull_up_disable, legacy_mode, scan_port_enable, async_timer_clock_select, ext_mem_enable;
    logic tap_in_instruction_shift, tap_in_data_shift, scan_tdo, scan_tdi_bit, scan_tms_bit;
    logic scan_tck_rise, scan_tck_fall, ext_mem_latch, ext_mem_read, ext_mem_write;
    logic timer_crystal_in, timer_crystal_out, go, h_tdi_v, h_tms_v, h_tck, h_tdi, h_tms;
    int n_mismatch = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    // wire levels from every driver
    assign pf_lvl = (pf_pin_oe & pf_pin_out) | (~pf_pin_oe & pf_drv);
    assign pf_pin_in = scan_port_enable ? {h_tdi, pf_lvl[6], h_tms, h_tck, pf_lvl[3:0]} : pf_lvl;
    assign pg_pin_in = (pg_pin_oe & pg_pin_out) | (~pg_pin_oe & pg_drv);

    pfg_override i_dut (.clk, .arst_n, .pf_port, .pf_dir, .pg_port, .pg_dir, .pull_up_disable,
        .legacy_mode, .scan_port_enable, .async_timer_clock_select, .ext_mem_enable,
        .tap_in_instruction_shift, .tap_in_data_shift, .scan_tdo, .scan_tdi_bit, .scan_tms_bit,
        .scan_tck_rise, .scan_tck_fall, .ext_mem_latch, .ext_mem_read, .ext_mem_write, .pf_pin_in,
        .pf_pin_out, .pf_pin_oe, .pf_pin_pullup, .pg_pin_in, .pg_pin_out, .pg_pin_oe, .pg_pin_pullup,
        .analog_pin_link, .timer_crystal_in, .timer_crystal_out, .pf_in_sync, .pg_in_sync);

    pfg_scan_host i_host (.go, .tdi_v(h_tdi_v), .tms_v(h_tms_v), .tck(h_tck), .tdi(h_tdi), .tms(h_tms));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // mode bits: legacy, scan, crystal, memory, pull-up disable
    task cfg(input logic [4:0] m, input logic [7:0] fp, input logic [7:0] fd, input int n);
        @(negedge clk);
        {legacy_mode, scan_port_enable, async_timer_clock_select, ext_mem_enable, pull_up_disable} = m;
        pf_port = fp;
        pf_dir = fd;
        repeat (n) @(negedge clk);
    endtask : cfg

    // wait for a one-cycle edge pulse, bounded
    task wait_pulse(input bit fall);
        int n;
        n = 0;
        while ((fall ? scan_tck_fall : scan_tck_rise) !== 1'h1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40) chk("pulse", 8'h00, 8'h01);
        go = 1'h0;
        @(negedge clk);
    endtask : wait_pulse

    // one scan bit through the host, shift flags and output bit from the state machine
    task send(input logic tdi, input logic tms, input logic ir, input logic dr, input logic tdo);
        @(negedge clk);
        {h_tdi_v, h_tms_v, tap_in_instruction_shift, tap_in_data_shift, scan_tdo} = {tdi, tms, ir, dr, tdo};
        go = 1'h1;
        wait_pulse(1'b0);
        chk("tdi_tms", {6'h00, scan_tdi_bit, scan_tms_bit}, {6'h00, tdi, tms});
        wait_pulse(1'b1);
        chk("tdo", {6'h00, pf_pin_oe[6], pf_pin_out[6]}, {6'h00, ir | dr, tdo});
    endtask : send

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        {pull_up_disable, legacy_mode, async_timer_clock_select, ext_mem_enable} = 4'h0;
        {tap_in_instruction_shift, tap_in_data_shift, scan_tdo, go, h_tdi_v, h_tms_v} = 6'h0;
        {ext_mem_latch, ext_mem_read, ext_mem_write} = 3'h0;
        {pf_port, pf_dir, pf_drv} = {8'hFF, 16'h0000};
        {pg_port, pg_dir, pg_drv} = 15'h0000;
        scan_port_enable = 1'h1;
        repeat (4) @(negedge clk);
        chk("pullup_rst", pf_pin_pullup, 8'hBF);
        repeat (4) @(negedge clk);
        arst_n = 1'h1;
        // plain port settings
        {pf_drv, pg_port, pg_dir, pg_drv} = {8'h5A, 5'h15, 5'h0C, 5'h0A};
        cfg(5'h00, 8'hA5, 8'h3C, 4);
        chk("pf_oe", pf_pin_oe, 8'h3C);
        chk("pf_out", pf_pin_out, 8'hA5);
        chk("pf_pu", pf_pin_pullup, 8'h81);
        chk("pf_sync", pf_in_sync, 8'h66);
        chk("analog", analog_pin_link, 8'h66);
        chk("pg_ctl", {pg_pin_oe, 3'h0}, {5'h0C, 3'h0});
        chk("pg_pu", {3'h0, pg_pin_pullup}, 8'h11);
        chk("pg_sync", {3'h0, pg_in_sync}, 8'h06);
        cfg(5'h01, 8'hA5, 8'h3C, 1);
        chk("pud", pf_pin_pullup, 8'h00);
        // legacy: port F inputs only, port G drives only alternate functions
        cfg(5'h10, 8'hA5, 8'h3C, 1);
        chk("legacy_f", pf_pin_oe, 8'h00);
        chk("legacy_g", {pg_pin_oe, 3'h0}, 8'h00);
        // memory strobes, every value, in and out of legacy mode
        for (int i = 0; i < 16; i++) begin
            cfg({i[3], 3'h1, 1'h0}, 8'hA5, 8'h3C, 0);
            {ext_mem_latch, ext_mem_read, ext_mem_write} = i[2:0];
            @(negedge clk);
            chk("mem", {pg_pin_oe[2:0], pg_pin_pullup[2:0], 2'h0}, 8'hE0);
            chk("mem_out", {5'h00, pg_pin_out[2:0]}, {5'h00, i[2:0]});
        end
        // crystal mode on G4 and G3
        {pg_port, pg_dir, pg_drv} = {5'h1F, 5'h1F, 5'h18};
        cfg(5'h04, 8'h00, 8'h00, 4);
        chk("xtal_ctl", {pg_pin_oe[4:3], pg_pin_pullup[4:3], pg_in_sync[4:3], 2'h0}, 8'h00);
        chk("xtal_in", {6'h00, timer_crystal_in, timer_crystal_out}, 8'h03);
        pg_drv = 5'h08;
        @(negedge clk);
        chk("xtal_lvl", {6'h00, timer_crystal_in, timer_crystal_out}, 8'h01);
        cfg(5'h00, 8'h00, 8'h00, 1);
        chk("xtal_off", {7'h00, timer_crystal_in}, 8'h00);
        // scan port; port F outputs held still meanwhile
        pf_drv = 8'hF0;
        cfg(5'h08, 8'hFF, 8'hFF, 4);
        chk("scan_pu", pf_pin_pullup, 8'hB0);
        chk("scan_oe", pf_pin_oe, 8'h0F);
        chk("scan_sync", pf_in_sync, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            send(i[0], i[1], i == 1, i == 2, ~i[0]);
        end
        wrap_up();
    end

    // watchdog
    initial begin
        #100us;
        n_mismatch++;
        wrap_up();
    end
endmodule : tb_top
